// >>> shared/oag_defines.vh
/*
  constants for the operand address generator: mode codes, instruction
  classes, target spaces and the working register window base.
  assumes inclusion by bare name from the design files.
*/
`ifndef OAG_DEFINES_VH
`define OAG_DEFINES_VH

// addressing mode codes carried on mode_i
`define OAG_MODE_REG      3'h0
`define OAG_MODE_WREG     3'h1
`define OAG_MODE_PTR      3'h2
`define OAG_MODE_INDEX    3'h3
`define OAG_MODE_ABS      3'h4
`define OAG_MODE_JOFS     3'h5
`define OAG_MODE_LIT      3'h6

// instruction classes carried on class_i
`define OAG_CLS_REGLOAD   3'h0
`define OAG_CLS_CODELOAD  3'h1
`define OAG_CLS_EXTLOAD   3'h2
`define OAG_CLS_ABSJUMP   3'h3
`define OAG_CLS_CALL      3'h4
`define OAG_CLS_SHORTJMP  3'h5
`define OAG_CLS_OTHER     3'h6

// operand target space on space_o
`define OAG_SPC_NONE      2'h0
`define OAG_SPC_RF        2'h1
`define OAG_SPC_CODE      2'h2
`define OAG_SPC_EXT       2'h3

// working register window base (c0h..cfh)
`define OAG_WREG_BASE     8'hc0

// index offset size selector
`define OAG_OFS_SHORT     1'b0
`define OAG_OFS_LONG      1'b1

`endif

// >>> verilog/oag_pair_reader.v
/*
  register pair fetch: reads the even (msb) then odd (lsb) byte of a
  16-bit pair from the register file, one byte per cycle.
  assumes the register file answers a read in the same cycle it is asked.
*/
`timescale 1ns/1ps
`default_nettype none

module oag_pair_reader (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // request
  input wire start_i,
  input wire [7:0] pair_addr_i,
  // register file port
  output wire [7:0] rf_addr_o,
  input wire [7:0] rf_data_i,
  // result
  output reg [15:0] pair_o,
  output wire done_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_HI = 3'b010;
  localparam ST_LO = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] base_reg;

  // pairs always start on an even address: force bit 0 low
  assign rf_addr_o = (state_reg == ST_LO) ? {base_reg[7:1], 1'b1} :
                     {base_reg[7:1], 1'b0};
  assign done_o = (state_reg == ST_LO);

  // sequence control
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = start_i ? ST_HI : ST_IDLE;
      ST_HI: state_next = ST_LO;
      ST_LO: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // msb lands from the even byte, lsb from the odd byte
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      base_reg <= 8'h00;
      pair_o <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && start_i)
        base_reg <= pair_addr_i;
      if (state_reg == ST_HI)
        pair_o[15:8] <= rf_data_i;
      if (state_reg == ST_LO)
        pair_o[7:0] <= rf_data_i;
    end
  end

endmodule // oag_pair_reader

`default_nettype wire

// >>> verilog/oag_addr_adder.v
/*
  wrapping address adder: 16-bit base plus sign-extended
  8-bit or full 16-bit offset, modulo 65536, result registered.
  assumes inputs are stable in the cycle load_i is high.
*/
`timescale 1ns/1ps
`default_nettype none

module oag_addr_adder (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // operands
  input wire load_i,
  input wire [15:0] base_i,
  input wire [15:0] ofs_i,
  input wire long_i,
  // result
  output reg [15:0] sum_o
);

  wire [15:0] ofs_ext;
  wire [16:0] full_sum;

  // short offsets are signed bytes, -128..+127
  assign ofs_ext = long_i ? ofs_i : {{8{ofs_i[7]}}, ofs_i[7:0]};
  assign full_sum = {1'b0, base_i} + {1'b0, ofs_ext};

  // carry out of bit 15 is dropped, no overflow flag
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      sum_o <= 16'h0000;
    else if (load_i)
      sum_o <= full_sum[15:0];
  end

endmodule // oag_addr_adder

`default_nettype wire

// >>> verilog/oag_operand_addr.v
/*
  operand address generation for an 8-bit core: turns a decoded
  instruction into a register file, code or external memory address,
  an immediate operand, or a new instruction pointer.
  assumes a decoder supplying mode, class and fields, and a register file
  with a combinational read port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oag_defines.vh"

module oag_operand_addr #(
  parameter RESET_VECTOR = 16'h0100
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // decoded instruction
  input wire start_i,
  input wire [2:0] mode_i,
  input wire [2:0] class_i,
  input wire [7:0] reg_field_i,
  input wire [7:0] ofs_lo_i,
  input wire [7:0] ofs_hi_i,
  input wire long_ofs_i,
  input wire to_ext_i,
  input wire [15:0] next_ip_i,
  input wire ip_step_i,
  // register file read port
  output wire [7:0] rf_addr_o,
  input wire [7:0] rf_data_i,
  // results
  output reg [1:0] space_o,
  output reg [15:0] opnd_addr_o,
  output reg [7:0] opnd_val_o,
  output reg opnd_is_val_o,
  output reg done_o,
  output reg illegal_o,
  output reg [15:0] ip_o,
  output wire [15:0] fetch_addr_o
);

  // ********************************************************************
  // helpers
  // ********************************************************************

  // window locations: 4-bit number placed over the c0h base
  function [7:0] wreg_loc;
    input [3:0] num;
    begin
      wreg_loc = `OAG_WREG_BASE | {4'h0, num};
    end
  endfunction

  // which modes each class may use
  function mode_ok;
    input [2:0] cls;
    input [2:0] md;
    begin
      case (cls)
        `OAG_CLS_REGLOAD: mode_ok = (md != `OAG_MODE_ABS) &&
                                    (md != `OAG_MODE_JOFS);
        `OAG_CLS_CODELOAD,
        `OAG_CLS_EXTLOAD: mode_ok = (md == `OAG_MODE_PTR) ||
                                    (md == `OAG_MODE_INDEX) ||
                                    (md == `OAG_MODE_ABS) ||
                                    (md == `OAG_MODE_WREG);
        `OAG_CLS_ABSJUMP,
        `OAG_CLS_CALL: mode_ok = (md == `OAG_MODE_ABS) ||
                                 (md == `OAG_MODE_PTR);
        `OAG_CLS_SHORTJMP: mode_ok = (md == `OAG_MODE_JOFS);
        `OAG_CLS_OTHER: mode_ok = (md != `OAG_MODE_INDEX) &&
                                  (md != `OAG_MODE_JOFS) &&
                                  (md != `OAG_MODE_ABS);
        default: mode_ok = 1'b0;
      endcase
    end
  endfunction

  // ********************************************************************
  // state and storage
  // ********************************************************************

  localparam ST_IDLE = 5'b00001;
  localparam ST_RD = 5'b00010;
  localparam ST_PAIR = 5'b00100;
  localparam ST_ADD = 5'b01000;
  localparam ST_DONE = 5'b10000;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [2:0] mode_reg;
  reg [2:0] class_reg;
  reg [7:0] field_reg;
  reg [15:0] ofs_reg;
  reg long_reg;
  reg ext_reg;
  reg [15:0] add_base;
  reg [15:0] add_ofs;
  reg add_long;
  reg add_load;
  reg [7:0] rf_rd_addr;
  reg [1:0] mem_space;

  wire [15:0] sum_w;
  wire [15:0] pair_w;
  wire pair_done_w;
  wire [7:0] pair_rf_addr_w;
  wire pair_start_w;
  wire [7:0] pair_base_w;
  wire is_jump_w;
  wire [7:0] rf_index_sum_w;

  // the pair reader owns the read port while it is busy
  assign rf_addr_o = (state_reg == ST_PAIR) ? pair_rf_addr_w : rf_rd_addr;
  assign fetch_addr_o = ip_o;
  assign is_jump_w = (class_reg == `OAG_CLS_ABSJUMP) ||
                     (class_reg == `OAG_CLS_CALL) ||
                     (class_reg == `OAG_CLS_SHORTJMP);
  // carry out of the byte add is lost on purpose
  assign rf_index_sum_w = ofs_reg[7:0] + rf_data_i;
  assign pair_start_w = (state_reg == ST_RD) && (state_next == ST_PAIR);
  // indexed memory bases sit in a working register pair, pointers anywhere
  assign pair_base_w = (mode_reg == `OAG_MODE_INDEX) ?
                       wreg_loc(field_reg[3:0]) : field_reg;

  // ********************************************************************
  // sub blocks
  // ********************************************************************

  oag_pair_reader i_oag_pair_reader (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .start_i(pair_start_w),
    .pair_addr_i(pair_base_w),
    .rf_addr_o(pair_rf_addr_w),
    .rf_data_i(rf_data_i),
    .pair_o(pair_w),
    .done_o(pair_done_w)
  );

  oag_addr_adder i_oag_addr_adder (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .load_i(add_load),
    .base_i(add_base),
    .ofs_i(add_ofs),
    .long_i(add_long),
    .sum_o(sum_w)
  );

  // ********************************************************************
  // control
  // ********************************************************************

  // target space of a memory-side access
  always @* begin
    if (is_jump_w || class_reg == `OAG_CLS_CODELOAD)
      mem_space = `OAG_SPC_CODE;
    else if (class_reg == `OAG_CLS_EXTLOAD || ext_reg)
      mem_space = `OAG_SPC_EXT;
    else
      mem_space = `OAG_SPC_CODE;
  end

  // register file address while reading the pointer or index
  always @* begin
    if (mode_reg == `OAG_MODE_INDEX && class_reg == `OAG_CLS_REGLOAD)
      rf_rd_addr = wreg_loc(field_reg[3:0]);
    else if (mode_reg == `OAG_MODE_WREG)
      rf_rd_addr = wreg_loc(field_reg[3:0]);
    else
      rf_rd_addr = field_reg;
  end

  // next state: pairs go through the pair reader, sums through adder
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_i) begin
          if (!mode_ok(class_i, mode_i))
            state_next = ST_DONE;
          else if (mode_i == `OAG_MODE_PTR ||
                   mode_i == `OAG_MODE_INDEX)
            state_next = ST_RD;
          else if (mode_i == `OAG_MODE_JOFS)
            state_next = ST_ADD;
          else
            state_next = ST_DONE;
        end
      end
      ST_RD: begin
        if (class_reg == `OAG_CLS_REGLOAD || class_reg == `OAG_CLS_OTHER)
          state_next = ST_DONE;
        else
          state_next = ST_PAIR;
      end
      ST_PAIR: begin
        if (pair_done_w)
          state_next = (mode_reg == `OAG_MODE_INDEX) ? ST_ADD : ST_DONE;
      end
      ST_ADD: state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // adder feed: pair base plus offset, or pointer plus displacement
  always @* begin
    add_load = 1'b0;
    add_base = pair_w;
    add_ofs = ofs_reg;
    add_long = long_reg;
    if (state_reg == ST_IDLE && start_i && mode_i == `OAG_MODE_JOFS) begin
      add_load = 1'b1;
      add_base = next_ip_i;
      add_ofs = {ofs_hi_i, ofs_lo_i};
      add_long = `OAG_OFS_SHORT;
    end else if (state_reg == ST_PAIR && pair_done_w) begin
      add_load = 1'b1;
      add_base = {pair_w[15:8], rf_data_i};
    end
  end

  // ********************************************************************
  // registers
  // ********************************************************************

  // capture fields, drive results and the instruction pointer
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      mode_reg <= 3'h0;
      class_reg <= 3'h0;
      field_reg <= 8'h00;
      ofs_reg <= 16'h0000;
      long_reg <= 1'b0;
      ext_reg <= 1'b0;
      space_o <= `OAG_SPC_NONE;
      opnd_addr_o <= 16'h0000;
      opnd_val_o <= 8'h00;
      opnd_is_val_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      ip_o <= RESET_VECTOR[15:0];
    end else begin
      state_reg <= state_next;
      done_o <= 1'b0;
      if (ip_step_i)
        ip_o <= next_ip_i;
      if (state_reg == ST_IDLE && start_i) begin
        mode_reg <= mode_i;
        class_reg <= class_i;
        field_reg <= reg_field_i;
        ofs_reg <= {ofs_hi_i, ofs_lo_i};
        long_reg <= long_ofs_i;
        ext_reg <= to_ext_i;
        illegal_o <= !mode_ok(class_i, mode_i);
        opnd_is_val_o <= 1'b0;
        space_o <= `OAG_SPC_NONE;
        case (mode_i)
          `OAG_MODE_REG: begin
            space_o <= `OAG_SPC_RF;
            opnd_addr_o <= {8'h00, reg_field_i};
          end
          `OAG_MODE_WREG: begin
            space_o <= `OAG_SPC_RF;
            opnd_addr_o <= {8'h00, wreg_loc(reg_field_i[3:0])};
          end
          `OAG_MODE_LIT: begin
            opnd_val_o <= ofs_lo_i;
            opnd_is_val_o <= 1'b1;
          end
          `OAG_MODE_ABS: begin
            opnd_addr_o <= {ofs_hi_i, ofs_lo_i};
            space_o <= (class_i == `OAG_CLS_EXTLOAD) ? `OAG_SPC_EXT :
                       `OAG_SPC_CODE;
            if (mode_ok(class_i, mode_i) &&
                (class_i == `OAG_CLS_ABSJUMP || class_i == `OAG_CLS_CALL))
              ip_o <= {ofs_hi_i, ofs_lo_i};
          end
          default: opnd_addr_o <= opnd_addr_o;
        endcase
      end
      // register file pointer or indexed register load result
      if (state_reg == ST_RD && state_next == ST_DONE) begin
        space_o <= `OAG_SPC_RF;
        if (mode_reg == `OAG_MODE_INDEX)
          opnd_addr_o <= {8'h00, rf_index_sum_w};
        else
          opnd_addr_o <= {8'h00, rf_data_i};
      end
      // plain pair pointer into code or external memory
      if (state_reg == ST_PAIR && pair_done_w &&
          mode_reg == `OAG_MODE_PTR) begin
        space_o <= mem_space;
        opnd_addr_o <= {pair_w[15:8], rf_data_i};
        if (is_jump_w)
          ip_o <= {pair_w[15:8], rf_data_i};
      end
      if (state_reg == ST_DONE) begin
        done_o <= 1'b1;
        // a refused index or relative mode leaves address and pointer untouched
        if (!illegal_o && mode_reg == `OAG_MODE_INDEX &&
            class_reg != `OAG_CLS_REGLOAD &&
            class_reg != `OAG_CLS_OTHER) begin
          space_o <= mem_space;
          opnd_addr_o <= sum_w;
        end
        if (!illegal_o && mode_reg == `OAG_MODE_JOFS) begin
          space_o <= `OAG_SPC_CODE;
          opnd_addr_o <= sum_w;
          ip_o <= sum_w;
        end
      end
    end
  end

endmodule // oag_operand_addr

`default_nettype wire

// >>> dv/oag_rf_model.sv
/* register file model behind the operand address generator.
   assumes a combinational read port: data follows the address. */
`timescale 1ns/1ps
`default_nettype none

module oag_rf_model (
  // read port
  input wire logic [7:0] rf_addr_i,
  output logic [7:0] rf_data_o
);
  // every byte differs from its neighbour, so a msb/lsb swap shows up
  assign rf_data_o = rf_addr_i ^ 8'h5a;
endmodule // oag_rf_model

`default_nettype wire

// >>> dv/oag_operand_addr_sva.sv
/* checker for oag_operand_addr: result and timing of each mode, only refusal for the indexed mode.
   assumes requests only while idle and ip_step_i quiet meanwhile. */
`timescale 1ns/1ps
`default_nettype none
`include "oag_defines.vh"

module oag_operand_addr_sva #(
  parameter RESET_VECTOR = 16'h0100
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // request
  input wire start_i,
  input wire [2:0] mode_i,
  input wire [2:0] class_i,
  input wire [7:0] reg_field_i,
  input wire [7:0] ofs_lo_i,
  input wire [7:0] ofs_hi_i,
  input wire [15:0] next_ip_i,
  // register file
  input wire [7:0] rf_addr_o,
  input wire [7:0] rf_data_i,
  // results
  input wire [1:0] space_o,
  input wire [15:0] opnd_addr_o,
  input wire [7:0] opnd_val_o,
  input wire opnd_is_val_o,
  input wire done_o,
  input wire illegal_o,
  input wire [15:0] ip_o,
  input wire [15:0] fetch_addr_o
);
  // ****************
  // helpers and properties
  // ****************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // request decodes and expected sums, kept apart from the design's maths
  wire rq_lit = start_i && mode_i == `OAG_MODE_LIT;
  wire rq_reg = start_i && mode_i == `OAG_MODE_REG;
  wire rq_wreg = start_i && mode_i == `OAG_MODE_WREG;
  wire rq_ptr = start_i && mode_i == `OAG_MODE_PTR;
  wire rq_abs = start_i && mode_i == `OAG_MODE_ABS;
  wire rq_rel = start_i && mode_i == `OAG_MODE_JOFS;
  wire rq_idx = start_i && mode_i == `OAG_MODE_INDEX;
  wire [15:0] rel_sum = next_ip_i + {{8{ofs_lo_i[7]}}, ofs_lo_i};
  wire [7:0] wreg_adr = `OAG_WREG_BASE | {4'h0, reg_field_i[3:0]};
  wire [7:0] even_adr = reg_field_i & 8'hfe;

  AST_FETCH: assert property (fetch_addr_o == ip_o)
    else $error("fetch address differs from pointer");
  AST_LIT: assert property (rq_lit |-> ##2 done_o && opnd_is_val_o
    && opnd_val_o == $past(ofs_lo_i, 2)) else $error("literal wrong");
  AST_REG: assert property (rq_reg |-> ##2 done_o
    && space_o == `OAG_SPC_RF && opnd_addr_o[7:0] == $past(reg_field_i, 2))
    else $error("register address wrong");
  AST_WREG: assert property (rq_wreg |-> ##2 done_o
    && opnd_addr_o[7:0] == $past(wreg_adr, 2))
    else $error("working register address wrong");
  AST_RFPTR: assert property (rq_ptr && class_i == `OAG_CLS_REGLOAD
    |-> ##2 rf_addr_o == $past(reg_field_i, 2)
    ##1 done_o && opnd_addr_o[7:0] == $past(rf_data_i, 1))
    else $error("register pointer wrong");
  AST_PAIR: assert property (rq_ptr && class_i == `OAG_CLS_CODELOAD
    |-> ##2 rf_addr_o == $past(even_adr, 2)
    ##1 rf_addr_o == ($past(even_adr, 3) | 8'h01)
    ##2 done_o && opnd_addr_o == {$past(rf_data_i, 3), $past(rf_data_i, 2)})
    else $error("pair pointer wrong");
  AST_ABS: assert property (rq_abs && class_i == `OAG_CLS_ABSJUMP
    |-> ##2 done_o && ip_o == $past({ofs_hi_i, ofs_lo_i}, 2))
    else $error("absolute jump wrong");
  AST_REL: assert property (rq_rel && class_i == `OAG_CLS_SHORTJMP
    |-> ##3 done_o && ip_o == $past(rel_sum, 3))
    else $error("relative target wrong");
  AST_REL_BAD: assert property (rq_rel && class_i != `OAG_CLS_SHORTJMP
    |-> ##2 done_o && illegal_o && ip_o == $past(ip_o, 2))
    else $error("relative mode not refused");
  AST_IDX_BAD: assert property (rq_idx && class_i == `OAG_CLS_OTHER
    |-> ##2 done_o && illegal_o) else $error("indexed mode not refused");
  AST_DONE: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");

  // main scenarios seen at least once
  cover property (rq_abs ##2 done_o);
  cover property (rq_rel ##3 done_o);
  cover property (rq_ptr ##5 done_o);
endmodule // oag_operand_addr_sva

bind oag_operand_addr oag_operand_addr_sva #(.RESET_VECTOR(RESET_VECTOR))
  i_oag_operand_addr_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .start_i(start_i), .mode_i(mode_i), .class_i(class_i),
  .reg_field_i(reg_field_i), .ofs_lo_i(ofs_lo_i), .ofs_hi_i(ofs_hi_i),
  .next_ip_i(next_ip_i), .rf_addr_o(rf_addr_o), .rf_data_i(rf_data_i),
  .space_o(space_o), .opnd_addr_o(opnd_addr_o), .opnd_val_o(opnd_val_o),
  .opnd_is_val_o(opnd_is_val_o), .done_o(done_o), .illegal_o(illegal_o),
  .ip_o(ip_o), .fetch_addr_o(fetch_addr_o));

`default_nettype wire

// >>> dv/tb_oag_operand_addr.sv
/* bench for oag_operand_addr: one task per scenario, rf model behind.
   assumes a 10 MHz clock and inputs changed at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
`include "oag_defines.vh"

module tb_oag_operand_addr;
  // ****************
  // signals, design and partner
  // ****************
  logic ref_clk_i = 0;
  logic rstn_i = 0;
  logic start_i = 0;
  logic long_ofs_i = 0;
  logic to_ext_i = 0;
  logic ip_step_i = 0;
  logic [2:0] mode_i = 0;
  logic [2:0] class_i = 0;
  logic [7:0] reg_field_i = 0;
  logic [7:0] ofs_lo_i = 0;
  logic [7:0] ofs_hi_i = 0;
  logic [15:0] next_ip_i = 0;
  wire [7:0] rf_addr_o, rf_data_i, opnd_val_o;
  wire [1:0] space_o;
  wire [15:0] opnd_addr_o, ip_o, fetch_addr_o;
  wire done_o, illegal_o, opnd_is_val_o;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  oag_operand_addr i_oag_operand_addr (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .start_i(start_i), .mode_i(mode_i), .class_i(class_i),
    .reg_field_i(reg_field_i), .ofs_lo_i(ofs_lo_i), .ofs_hi_i(ofs_hi_i),
    .long_ofs_i(long_ofs_i), .to_ext_i(to_ext_i), .next_ip_i(next_ip_i),
    .ip_step_i(ip_step_i), .rf_addr_o(rf_addr_o), .rf_data_i(rf_data_i),
    .space_o(space_o), .opnd_addr_o(opnd_addr_o), .opnd_val_o(opnd_val_o),
    .opnd_is_val_o(opnd_is_val_o), .done_o(done_o), .illegal_o(illegal_o),
    .ip_o(ip_o), .fetch_addr_o(fetch_addr_o));
  oag_rf_model i_oag_rf_model (.rf_addr_i(rf_addr_o), .rf_data_o(rf_data_i));

  // clock and hang guard; the whole run needs under a hundred cycles
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  // one request, wait for done, then a spare cycle before the next take
  task automatic op(input logic [2:0] md, cl, input logic [7:0] fld, lo, hi,
                    input logic lng, input int lat);
    int k;
    mode_i = md;
    class_i = cl;
    reg_field_i = fld;
    ofs_lo_i = lo;
    ofs_hi_i = hi;
    long_ofs_i = lng;
    start_i = 1;
    @(negedge ref_clk_i);
    start_i = 0;
    k = 1;
    while (done_o !== 1'b1 && k < 12) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk("latency", 16'(lat), 16'(k));
    @(negedge ref_clk_i);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_lit_reg();
    op(`OAG_MODE_LIT, `OAG_CLS_REGLOAD, 8'h00, 8'haa, 8'h00, 0, 2);
    chk("lit", 16'h00aa, {8'h00, opnd_val_o});
    chk("is_val", 16'h0001, {15'h0, opnd_is_val_o});
    chk("lit space", 16'h0000, {14'h0, space_o});
    op(`OAG_MODE_REG, `OAG_CLS_REGLOAD, 8'h40, 8'h00, 8'h00, 0, 2);
    chk("reg", 16'h0040, opnd_addr_o);
    chk("reg space", 16'h0001, {14'h0, space_o});
    chk("reg not val", 16'h0000, {15'h0, opnd_is_val_o});
  endtask

  task automatic t_wreg();
    for (int i = 0; i < 16; i += 15) begin
      op(`OAG_MODE_WREG, `OAG_CLS_REGLOAD, 8'h30 | 8'(i), 8'h0, 8'h0, 0, 2);
      chk("wreg", 16'h00c0 | 16'(i), opnd_addr_o);
    end
  endtask

  task automatic t_rf_ptr_idx();
    op(`OAG_MODE_PTR, `OAG_CLS_REGLOAD, 8'h37, 8'h00, 8'h00, 0, 3);
    chk("rf ptr", {8'h00, 8'h37 ^ 8'h5a}, opnd_addr_o);
    // base plus working register c3h must drop its carry
    op(`OAG_MODE_INDEX, `OAG_CLS_REGLOAD, 8'h03, 8'hf0, 8'h00, 0, 3);
    chk("rf idx", {8'h00, 8'hf0 + (8'hc3 ^ 8'h5a)}, opnd_addr_o);
  endtask

  task automatic t_pair();
    op(`OAG_MODE_PTR, `OAG_CLS_CODELOAD, 8'h45, 8'h00, 8'h00, 0, 5);
    chk("pair", {8'h44 ^ 8'h5a, 8'h45 ^ 8'h5a}, opnd_addr_o);
    chk("code space", 16'h0002, {14'h0, space_o});
    op(`OAG_MODE_PTR, `OAG_CLS_EXTLOAD, 8'h45, 8'h00, 8'h00, 0, 5);
    chk("ext space", 16'h0003, {14'h0, space_o});
    op(`OAG_MODE_PTR, `OAG_CLS_ABSJUMP, 8'h45, 8'h00, 8'h00, 0, 5);
    chk("ptr jump", {8'h44 ^ 8'h5a, 8'h45 ^ 8'h5a}, ip_o);
  endtask

  task automatic t_mem_idx();
    // pair c2h/c3h holds 9899h; short offset 80h is -128
    op(`OAG_MODE_INDEX, `OAG_CLS_CODELOAD, 8'h02, 8'h80, 8'h00, 0, 6);
    chk("idx short", 16'h9899 - 16'h0080, opnd_addr_o);
    op(`OAG_MODE_INDEX, `OAG_CLS_EXTLOAD, 8'h02, 8'h00, 8'hff, 1, 6);
    chk("idx long", 16'h9899 + 16'hff00, opnd_addr_o);
    chk("idx space", 16'h0003, {14'h0, space_o});
    op(`OAG_MODE_INDEX, `OAG_CLS_OTHER, 8'h02, 8'h00, 8'h00, 0, 2);
    chk("idx refused", 16'h0001, {15'h0, illegal_o});
  endtask

  task automatic t_abs();
    op(`OAG_MODE_ABS, `OAG_CLS_CODELOAD, 8'h00, 8'h34, 8'h12, 0, 2);
    chk("abs load", 16'h1234, opnd_addr_o);
    op(`OAG_MODE_ABS, `OAG_CLS_ABSJUMP, 8'h00, 8'h78, 8'h56, 0, 2);
    chk("jump", 16'h5678, ip_o);
    chk("jump legal", 16'h0000, {15'h0, illegal_o});
    op(`OAG_MODE_ABS, `OAG_CLS_CALL, 8'h00, 8'hbc, 8'h9a, 0, 2);
    chk("call", 16'h9abc, fetch_addr_o);
  endtask

  task automatic t_rel();
    next_ip_i = 16'hfff0;
    op(`OAG_MODE_JOFS, `OAG_CLS_SHORTJMP, 8'h00, 8'h7f, 8'h00, 0, 3);
    chk("rel wrap", 16'h006f, ip_o);
    next_ip_i = 16'h0200;
    op(`OAG_MODE_JOFS, `OAG_CLS_SHORTJMP, 8'h00, 8'h80, 8'h00, 0, 3);
    chk("rel back", 16'h0180, ip_o);
    op(`OAG_MODE_JOFS, `OAG_CLS_OTHER, 8'h00, 8'h10, 8'h00, 0, 2);
    chk("rel refused", 16'h0001, {15'h0, illegal_o});
    chk("ip kept", 16'h0180, ip_o);
  endtask

  task automatic t_step_reset();
    next_ip_i = 16'h2345;
    ip_step_i = 1;
    @(negedge ref_clk_i);
    ip_step_i = 0;
    chk("step", 16'h2345, fetch_addr_o);
    rstn_i = 0;
    @(negedge ref_clk_i);
    rstn_i = 1;
    chk("reset ip", 16'h0100, fetch_addr_o);
    @(negedge ref_clk_i);
  endtask

  initial begin
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1;
    @(negedge ref_clk_i);
    chk("start ip", 16'h0100, ip_o);
    t_lit_reg();
    t_wreg();
    t_rf_ptr_idx();
    t_pair();
    t_mem_idx();
    t_abs();
    t_rel();
    t_step_reset();
    t_lit_reg();
    test_done();
  end
endmodule // tb_oag_operand_addr

`default_nettype wire
